// File: hdl/frc_calib_ctrl.sv
// Filter/range control, bias calibration and global commands over SPI
// ============================================================
`timescale 1ns/1ps
module frc_calib_ctrl #(
  parameter int          FLASH_CYC_P   = frc_pkg::FLASH_CYC,
  parameter int          RESTORE_CYC_P = frc_pkg::RESTORE_CYC,
  parameter int          SWRST_CYC_P   = frc_pkg::SWRST_CYC,
  parameter int          RAW_W         = frc_pkg::RAW_W,
  parameter logic [15:0] PROD_CODE     = 16'h5A5A, // Arbitrary value
  parameter logic [15:0] LOT_LO        = 16'h1111, // Arbitrary value
  parameter logic [15:0] LOT_HI        = 16'h2222, // Arbitrary value
  parameter logic [15:0] SERIAL        = 16'h0001  // Arbitrary value
) (
  // Core clock and reset
  input  wire logic                         clk_i,
  input  wire logic                         rstn_i,
  // SPI link
  input  wire logic                         sclk_i,
  input  wire logic                         cs_n_i,
  input  wire logic                         mosi_i,
  output logic                              miso_o,
  // Raw samples, gyro in 0.0125 deg/s, accel in mg
  input  wire logic                         sample_i,
  input  wire logic signed [RAW_W-1:0]      gyro_x_raw_i,
  input  wire logic signed [RAW_W-1:0]      gyro_y_raw_i,
  input  wire logic signed [RAW_W-1:0]      gyro_z_raw_i,
  input  wire logic signed [RAW_W-1:0]      accel_x_raw_i,
  input  wire logic signed [RAW_W-1:0]      accel_y_raw_i,
  input  wire logic signed [RAW_W-1:0]      accel_z_raw_i,
  // Processed outputs
  output logic [frc_pkg::DATA_W-1:0]        gyro_x_output_o,
  output logic [frc_pkg::DATA_W-1:0]        gyro_y_output_o,
  output logic [frc_pkg::DATA_W-1:0]        gyro_z_output_o,
  output logic [frc_pkg::DATA_W-1:0]        accel_x_output_o,
  output logic [frc_pkg::DATA_W-1:0]        accel_y_output_o,
  output logic [frc_pkg::DATA_W-1:0]        accel_z_output_o,
  output logic                              data_valid_o,
  // Compensation enables and status
  output logic                              pop_en_o,
  output logic                              ling_comp_en_o,
  output logic                              cmd_busy_o
);
  import frc_pkg::*;
  localparam int FW = RAW_W + 2;
  localparam int SW = FW + 8;
  localparam int DW = DATA_W;

  typedef struct packed {
    logic [2:0]        sync;
    logic              seen;
    logic [5:0][15:0]  off;
    logic [15:0]       frc;
    logic [15:0]       misc;
    logic [7:0]        cmd;
    logic [15:0]       rdata;
    logic [5:0][15:0]  f_off;
    logic [15:0]       f_frc;
    logic [15:0]       f_misc;
    logic [15:0]       fcnt;
    frc_state_t        st;
    logic [31:0]       tmr;
    logic [6:0]        ptr;
    logic [7:0]        fill;
    logic [2:0]        last_b;
    logic              upd;
    logic              clr;
    logic              arm;
    logic              busy;
  } frc_core_t;

  frc_core_t q;
  frc_core_t d;

  // ==========================================================
  // Link domain: a frame ends on the 16th rising SCLK edge; chip select only clears the count, the shift registers and miso_q
  logic [3:0]  bit_cnt;
  logic [14:0] sh_in;
  logic [15:0] frame_q;
  logic        frame_tgl;
  logic [15:0] sh_out;
  logic        miso_q;

  always_ff @(posedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      bit_cnt <= 4'h0;
      sh_in   <= 15'h0000;
    end
    else
    begin
      bit_cnt <= bit_cnt + 4'h1;
      sh_in   <= {sh_in[13:0], mosi_i};
    end
  end

  always_ff @(posedge sclk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      frame_q   <= 16'h0000;
      frame_tgl <= 1'b0;
    end
    else if (bit_cnt == 4'hF)
    begin
      frame_q   <= {sh_in, mosi_i};
      frame_tgl <= ~frame_tgl;
    end
  end

  // Read word is only changed by the core right after a frame
  // arrives, so it is quiet when the next frame starts.
  always_ff @(negedge sclk_i or posedge cs_n_i)
  begin
    if (cs_n_i)
    begin
      sh_out <= 16'h0000;
      miso_q <= 1'b0;
    end
    else if (bit_cnt == 4'h0)
    begin
      miso_q <= q.rdata[15];
      sh_out <= {q.rdata[14:0], 1'b0};
    end
    else
    begin
      miso_q <= sh_out[15];
      sh_out <= {sh_out[14:0], 1'b0};
    end
  end
  assign miso_o = miso_q;

  // ==========================================================
  // Frame decode in the core domain
  logic       new_frame;
  logic       is_wr;
  logic [6:0] a_even;
  logic       a_hi;
  logic [7:0] wd;
  logic [2:0] eff_b;
  logic [1:0] gshift;
  logic [7:0] nb;
  logic [6:0] idx;
  logic       flt_rst;

  assign new_frame = (q.sync[2] == q.sync[1]) && (q.sync[2] != q.seen);
  assign is_wr     = frame_q[15];
  assign a_even    = {frame_q[14:9], 1'b0};
  assign a_hi      = frame_q[8];
  assign wd        = frame_q[7:0];

  always_comb
  begin
    eff_b = q.frc[TAP_LSB +: 3];
    if (q.frc[RNG_LSB +: 3] == RNG_75 && eff_b < MIN_75)
      eff_b = MIN_75;
    else if (q.frc[RNG_LSB +: 3] == RNG_150 && eff_b < MIN_150)
      eff_b = MIN_150;
    if (q.frc[RNG_LSB +: 3] == RNG_75)
      gshift = 2'd0;
    else if (q.frc[RNG_LSB +: 3] == RNG_150)
      gshift = 2'd1;
    else
      gshift = 2'd2;
  end

  assign nb      = 8'h01 << eff_b;
  assign idx     = q.ptr - nb[6:0];
  // Tap change restarts both averages so sums match their history
  assign flt_rst = q.clr || (eff_b != q.last_b);

  function automatic logic [15:0] rd_val(input logic [6:0] a);
    logic [15:0] v;
    v = 16'h0000;
    if (a == A_FCNT)
      v = q.fcnt;
    else if (a == A_MISC)
      v = q.misc;
    else if (a == A_FRC)
      v = q.frc;
    else if (a == A_CMD)
      v = {8'h00, q.cmd};
    else if (a == A_LOT_LO)
      v = LOT_LO;
    else if (a == A_LOT_HI)
      v = LOT_HI;
    else if (a == A_PROD)
      v = PROD_CODE;
    else if (a == A_SER)
      v = SERIAL;
    else
      for (int i = 0; i < 6; i++)
        if (a == A_OFF[i])
          v = q.off[i];
    return v;
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old);
    return a_hi ? {wd, old[7:0]} : {old[15:8], wd};
  endfunction

  // ==========================================================
  // Sensor path: offset, two cascaded moving averages, range scale on the gyro channels
  logic signed [RAW_W-1:0] raw_a [6];
  logic [DW-1:0]           out_a [6];
  logic signed [14:0]      nul_v [3];

  assign raw_a[0] = gyro_x_raw_i;
  assign raw_a[1] = gyro_y_raw_i;
  assign raw_a[2] = gyro_z_raw_i;
  assign raw_a[3] = accel_x_raw_i;
  assign raw_a[4] = accel_y_raw_i;
  assign raw_a[5] = accel_z_raw_i;

  function automatic logic [DW-1:0] sat_d(input logic signed [FW-1:0] v);
    logic signed [FW-1:0] mx;
    mx = FW'((1 << (DW - 1)) - 1);
    if (v > mx)
      return mx[DW-1:0];
    if (v < -mx - FW'(1))
      return ~mx[DW-1:0];
    return v[DW-1:0];
  endfunction

  function automatic logic [12:0] sat_o(input logic signed [14:0] v);
    if (v > 15'sh0FFF)
      return 13'h0FFF;
    if (v < -15'sh1000)
      return 13'h1000;
    return v[12:0];
  endfunction

  for (genvar ch = 0; ch < 6; ch++)
  begin : g_ch
    logic signed [FW-1:0] m1 [DEPTH];
    logic signed [FW-1:0] m2 [DEPTH];
    logic signed [SW-1:0] s1_q;
    logic signed [SW-1:0] s2_q;
    logic signed [SW-1:0] s1_n;
    logic signed [SW-1:0] s2_n;
    logic signed [FW-1:0] x;
    logic signed [FW-1:0] y1;
    logic signed [FW-1:0] y2;
    logic signed [FW-1:0] o1;
    logic signed [FW-1:0] o2;
    logic signed [15:0]   off_s;
    logic [DW-1:0]        out_q;

    assign off_s = (ch < 3) ? {{3{q.off[ch][12]}}, q.off[ch][12:0]}
                            : {{4{q.off[ch][11]}}, q.off[ch][11:0]};
    always_comb
    begin
      x    = FW'(raw_a[ch]) + FW'(off_s);
      o1   = (q.fill >= nb) ? m1[idx] : '0;
      s1_n = s1_q + SW'(x) - SW'(o1);
      y1   = FW'(s1_n >>> eff_b);
      o2   = (q.fill >= nb) ? m2[idx] : '0;
      s2_n = s2_q + SW'(y1) - SW'(o2);
      y2   = FW'(s2_n >>> eff_b);
    end

    always_ff @(posedge clk_i)
    begin
      if (sample_i)
      begin
        m1[q.ptr] <= x;
        m2[q.ptr] <= y1;
      end
    end

    always_ff @(posedge clk_i)
    begin
      if (!rstn_i || flt_rst)
      begin
        s1_q <= '0;
        s2_q <= '0;
      end
      else if (sample_i)
      begin
        s1_q <= s1_n;
        s2_q <= s2_n;
      end
      if (!rstn_i || q.clr)
        out_q <= '0;
      else if (sample_i && !flt_rst)
        out_q <= sat_d(y2 >>> ((ch < 3) ? gshift : 2'd0));
    end
    assign out_a[ch] = out_q;
    if (ch < 3)
    begin : g_nul
      assign nul_v[ch] = -15'(signed'(out_q));
    end
  end

  // ==========================================================
  // Registers, commands and flash mirror
  always_comb
  begin
    d      = q;
    d.sync = {q.sync[1:0], frame_tgl};
    d.upd  = sample_i && !flt_rst;
    d.clr  = 1'b0;
    d.last_b = eff_b;
    if (flt_rst)
      d.fill = 8'h00;
    else if (sample_i && q.fill < 8'(DEPTH))
      d.fill = q.fill + 8'h01;
    if (sample_i)
      d.ptr = q.ptr + 7'h01;
    if (new_frame)
    begin
      d.seen = q.sync[2];
      if (!is_wr)
        d.rdata = rd_val(a_even);
      else if (q.st == S_IDLE)
      begin
        if (a_even == A_FRC)
          d.frc = merge(q.frc) & FRC_MASK;
        else if (a_even == A_MISC)
          d.misc = merge(q.misc) & MISC_MASK;
        else if (a_even == A_CMD && !a_hi)
          d.cmd = wd & CMD_MASK;
        else
          for (int i = 0; i < 6; i++)
            if (a_even == A_OFF[i])
              d.off[i] = merge(q.off[i]) & OFF_MASK[i];
      end
    end
    case (q.st)
      S_IDLE:
      begin
        if (q.cmd[C_SWRST])
        begin
          d.off  = q.f_off;
          d.frc  = q.f_frc;
          d.misc = q.f_misc;
          d.clr  = 1'b1;
          d.tmr  = 32'(SWRST_CYC_P - 1);
          d.st   = S_SWRST;
        end
        else if (q.cmd[C_RESTORE])
        begin
          d.off = '0;
          d.clr = 1'b1;
          d.tmr = 32'(RESTORE_CYC_P - 1);
          d.st  = S_RESTORE;
        end
        else if (q.cmd[C_NULL])
        begin
          d.frc[RNG_LSB +: 3] = RNG_75;
          d.arm = 1'b0;
          d.st = S_NULL;
        end
        else if (q.cmd[C_FLASH])
        begin
          d.tmr = 32'(FLASH_CYC_P - 1);
          d.st  = S_FLASH;
        end
      end
      S_NULL:
      begin
        // Output refresh at the current update rate; an update
        // already in flight was scaled with the old range
        if (sample_i && !flt_rst)
          d.arm = 1'b1;
        if (q.upd && q.arm)
        begin
          d.arm = 1'b0;
          for (int i = 0; i < 3; i++)
            d.off[i] = {3'b000, sat_o(nul_v[i])};
          d.tmr = 32'(FLASH_CYC_P - 1);
          d.st  = S_FLASH;
        end
      end
      S_FLASH, S_RESTORE, S_SWRST:
      begin
        d.tmr = q.tmr - 32'd1;
        if (q.tmr == 32'd0)
        begin
          if (q.st != S_SWRST)
          begin
            d.f_off  = q.off;
            d.f_frc  = q.frc;
            d.f_misc = q.misc;
            d.fcnt   = q.fcnt + 16'h0001;
          end
          d.cmd = 8'h00;
          d.st  = S_IDLE;
        end
      end
      default:
        d.st = S_IDLE;
    endcase
    d.busy = (d.cmd != 8'h00);
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      q        <= '0;
      q.frc    <= FRC_RST;
      q.misc   <= MISC_RST;
      q.f_frc  <= FRC_RST;
      q.f_misc <= MISC_RST;
      q.last_b <= FRC_RST[TAP_LSB +: 3];
      q.st     <= S_IDLE;
    end
    else
      q <= d;
  end

  assign gyro_x_output_o  = out_a[0];
  assign gyro_y_output_o  = out_a[1];
  assign gyro_z_output_o  = out_a[2];
  assign accel_x_output_o = out_a[3];
  assign accel_y_output_o = out_a[4];
  assign accel_z_output_o = out_a[5];
  assign data_valid_o     = q.upd;
  assign pop_en_o         = q.misc[POP_BIT];
  assign ling_comp_en_o   = q.misc[LING_BIT];
  assign cmd_busy_o       = q.busy;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  property p_rst_val;
    $rose(rstn_i) |-> q.frc == FRC_RST && q.cmd == 8'h00;
  endproperty
  a_rst_val: assert property (p_rst_val) else $error("bad reset");

  property p_min75;
    q.frc[RNG_LSB +: 3] == RNG_75 |-> eff_b >= MIN_75;
  endproperty
  a_min75: assert property (p_min75) else $error("taps low");

  property p_min150;
    q.frc[RNG_LSB +: 3] == RNG_150 && q.frc[2:0] < MIN_150
      |-> eff_b == MIN_150;
  endproperty
  a_min150: assert property (p_min150) else $error("no clamp");

  property p_null;
    q.st == S_NULL && q.upd && q.arm |=> q.st == S_FLASH &&
      q.off[0][12:0] == sat_o($past(nul_v[0]));
  endproperty
  a_null: assert property (p_null) else $error("null wrong");

  property p_selfclr;
    q.st != S_IDLE ##1 q.st == S_IDLE |-> q.cmd == 8'h00;
  endproperty
  a_selfclr: assert property (p_selfclr) else $error("no clear");

  property p_restore;
    q.st == S_IDLE && !q.cmd[C_SWRST] && q.cmd[C_RESTORE]
      |=> q.off == '0 ##1 q.upd == 1'b0 || out_a[0] == '0;
  endproperty
  a_restore: assert property (p_restore) else $error("no zero");

  property p_unused;
    (q.cmd & ~CMD_MASK) == 8'h00;
  endproperty
  a_unused: assert property (p_unused) else $error("bad bit");

  property p_backup;
    q.st == S_FLASH && q.tmr == 32'd0 |=> q.f_frc == $past(q.frc)
      && q.fcnt == $past(q.fcnt) + 16'h0001;
  endproperty
  a_backup: assert property (p_backup) else $error("no backup");

  property p_flash_time;
    q.st != S_FLASH ##1 q.st == S_FLASH |-> q.tmr == FLASH_CYC_P - 1;
  endproperty
  a_flash_time: assert property (p_flash_time) else $error("time");

  property p_busy_wr;
    q.st != S_IDLE && new_frame && is_wr && a_even == A_FRC
      |=> $stable(q.frc);
  endproperty
  a_busy_wr: assert property (p_busy_wr) else $error("busy wr");

  c_null: cover property (q.st == S_NULL ##1 q.st == S_FLASH);
  c_restore: cover property (q.st == S_RESTORE ##1 q.st == S_IDLE);
  c_swrst: cover property (q.st == S_SWRST ##1 q.st == S_IDLE);
endmodule

// File: hdl/frc_pkg.sv
// Constants and types for the filter, range and calibration block
package frc_pkg;
  // ==========================================================
  // Timing
  localparam longint CLK_PS      = 4000;
  localparam longint PS_PER_MS   = 64'd1000000000;
  localparam longint FLASH_MS    = 75;
  localparam longint RESTORE_MS  = 50;
  localparam longint SWRST_MS    = 60;
  localparam int     FLASH_CYC   = int'(FLASH_MS * PS_PER_MS / CLK_PS);
  localparam int     RESTORE_CYC = int'(RESTORE_MS * PS_PER_MS / CLK_PS);
  localparam int     SWRST_CYC   = int'(SWRST_MS * PS_PER_MS / CLK_PS);
  // ==========================================================
  // Byte addresses (lower byte; upper byte is address + 1)
  localparam logic [6:0] A_FCNT   = 7'h00;
  localparam logic [6:0] A_GPIO   = 7'h32;
  localparam logic [6:0] A_MISC   = 7'h34;
  localparam logic [6:0] A_FRC    = 7'h38;
  localparam logic [6:0] A_DIAG   = 7'h3C;
  localparam logic [6:0] A_CMD    = 7'h3E;
  localparam logic [6:0] A_LOT_LO = 7'h52;
  localparam logic [6:0] A_LOT_HI = 7'h54;
  localparam logic [6:0] A_PROD   = 7'h56;
  localparam logic [6:0] A_SER    = 7'h58;
  localparam logic [0:5][6:0] A_OFF =
    {7'h1A, 7'h1C, 7'h1E, 7'h20, 7'h22, 7'h24};
  localparam logic [0:5][15:0] OFF_MASK =
    {16'h1FFF, 16'h1FFF, 16'h1FFF, 16'h0FFF, 16'h0FFF, 16'h0FFF};
  // ==========================================================
  // Fields and reset values
  localparam int          TAP_LSB   = 0;
  localparam int          RNG_LSB   = 8;
  localparam logic [2:0]  RNG_300   = 3'h4;
  localparam logic [2:0]  RNG_150   = 3'h2;
  localparam logic [2:0]  RNG_75    = 3'h1;
  localparam logic [2:0]  MIN_150   = 3'h2;
  localparam logic [2:0]  MIN_75    = 3'h4;
  localparam logic [15:0] FRC_RST   = 16'h0402;
  localparam logic [15:0] FRC_MASK  = 16'h0707;
  localparam logic [15:0] MISC_RST  = 16'h0006;
  localparam logic [15:0] MISC_MASK = 16'h00C7;
  localparam int          POP_BIT   = 6;
  localparam int          LING_BIT  = 7;
  localparam int          C_NULL    = 0;
  localparam int          C_RESTORE = 1;
  localparam int          C_FLASH   = 3;
  localparam int          C_SWRST   = 7;
  localparam logic [7:0]  CMD_MASK  = 8'h8B;
  localparam int          DATA_W    = 14;
  localparam int          RAW_W     = 16;
  localparam int          DEPTH     = 128;
  typedef enum logic [2:0] {
    S_IDLE, S_NULL, S_FLASH, S_RESTORE, S_SWRST
  } frc_state_t;
endpackage

// File: test/frc_spi_host.sv
// Host model: SPI mode 3 master driving the sensor's serial port
`timescale 1ns/1ps
module frc_spi_host (
  // SPI link
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      mosi_o,
  input  wire logic miso_i
);
  initial
  begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  // ==========================================================
  // One 16-bit frame, MSB first, clock parked high outside it
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n_o = 1'b0;
    #41.3;
    for (int i = 15; i >= 0; i--)
    begin
      sclk_o = 1'b0;
      mosi_o = w[i];
      #80;
      sclk_o = 1'b1;
      r[i] = miso_i;
      #80;
    end
    // Released data line must not keep looking valid
    mosi_o = ~w[0];
    cs_n_o = 1'b1;
    #203.7;
  endtask
endmodule

// File: test/filter_range_calib_commands_test.sv
// Self-checking bench for the filter, range and calibration block
`timescale 1ns/1ps
module filter_range_calib_commands_test;
  import frc_pkg::*;
  logic              clk_i = 1'b0;
  logic              rstn_i = 1'b0;
  logic              sample_i = 1'b0;
  logic              sclk, cs_n, mosi, miso;
  logic              data_valid_o, pop_en_o, ling_comp_en_o, cmd_busy_o;
  logic [2:0]        cnt = 3'h0;
  logic signed [15:0] raw [0:5] = '{default: 16'h0000};
  logic [13:0]       out [0:5];
  logic [15:0]       rv;
  int                off [0:5];
  int                seed = 5011;
  int                error_cnt = 0;
  int                tests_run = 0;
  logic [0:2][2:0]   rngs = {RNG_75, RNG_150, RNG_300};
  logic [0:2][7:0]   miscs = {8'h46, 8'h86, 8'h06};

  always #2 clk_i = ~clk_i;
  // Short command times; backup outlasts one frame for the busy write
  frc_calib_ctrl #(.FLASH_CYC_P(1000), .RESTORE_CYC_P(200),
    .SWRST_CYC_P(200)) frc_calib_ctrl_i (
    .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .mosi_i(mosi), .miso_o(miso), .sample_i(sample_i),
    .gyro_x_raw_i(raw[0]), .gyro_y_raw_i(raw[1]), .gyro_z_raw_i(raw[2]),
    .accel_x_raw_i(raw[3]), .accel_y_raw_i(raw[4]),
    .accel_z_raw_i(raw[5]), .gyro_x_output_o(out[0]),
    .gyro_y_output_o(out[1]), .gyro_z_output_o(out[2]),
    .accel_x_output_o(out[3]), .accel_y_output_o(out[4]),
    .accel_z_output_o(out[5]), .data_valid_o(data_valid_o),
    .pop_en_o(pop_en_o), .ling_comp_en_o(ling_comp_en_o),
    .cmd_busy_o(cmd_busy_o));
  frc_spi_host frc_spi_host_i (.sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso));

  always @(posedge clk_i)
  begin
    cnt <= cnt + 3'h1;
    sample_i <= (cnt == 3'h7);
  end
  // ==========================================================
  // Helpers
  task automatic stop_test();
    $display("errors %0d, checks %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle();
    for (int i = 0; i < 5000 && cmd_busy_o !== 1'b0; i++)
      @(posedge clk_i);
    if (cmd_busy_o !== 1'b0)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    idle();
    frc_spi_host_i.xfer({1'b1, a, d}, r);
  endtask
  task automatic rd(input logic [6:0] a);
    idle();
    frc_spi_host_i.xfer({1'b0, a, 8'h00}, rv);
    frc_spi_host_i.xfer(16'h0000, rv);
  endtask
  task automatic wsamp(input int n);
    int k;
    k = 0;
    for (int i = 0; i < n * 20 && k < n; i++)
    begin
      @(posedge clk_i);
      #1;
      if (data_valid_o === 1'b1)
        k++;
    end
    if (k < n)
    begin
      error_cnt++;
      stop_test();
    end
  endtask
  task automatic setraw();
    @(posedge clk_i);
    for (int i = 0; i < 6; i++)
      raw[i] <= 16'(($random(seed) % 500) * 4);
  endtask
  function automatic logic [15:0] ex(int v, int sh);
    v = v >>> sh;
    if (v > 8191)
      v = 8191;
    if (v < -8192)
      v = -8192;
    return {2'b00, v[13:0]};
  endfunction
  task automatic chkout(input int sh);
    for (int i = 0; i < 6; i++)
      chk({2'b00, out[i]}, ex(raw[i]+off[i], i < 3 ? sh : 0));
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    repeat (16) @(posedge clk_i);
    rstn_i <= 1'b1;
    setraw();
    rd(A_FRC);
    chk(rv, FRC_RST);
    rd(A_MISC);
    chk(rv, MISC_RST);
    rd(A_CMD);
    chk(rv, 16'h0000);
    rd(7'h40);
    chk(rv, 16'h0000);
    for (int i = 0; i < 6; i++)
    begin
      rd(A_OFF[i]);
      chk(rv, 16'h0000);
      off[i] = ($random(seed) % 250) * 4;
      wr(A_OFF[i] + 7'h01, 8'(off[i] >> 8));
      wr(A_OFF[i], 8'(off[i]));
      rd(A_OFF[i]);
      chk(rv, 16'(off[i]) & OFF_MASK[i]);
    end
    // Range first, then tap 1, under the minimum of the 75 and 150 ranges
    for (int g = 0; g < 3; g++)
    begin
      wr(A_FRC + 7'h01, {5'h00, rngs[g]});
      wr(A_FRC, 8'h01);
      rd(A_FRC);
      chk(rv, {5'h00, rngs[g], 8'h01});
      wsamp(40);
      chkout(g);
    end
    // One tap per stage follows a step at once
    wr(A_FRC, 8'h00);
    wsamp(3);
    setraw();
    wsamp(2);
    chkout(2);
    for (int m = 0; m < 3; m++)
    begin
      wr(A_MISC, miscs[m]);
      chk({14'h0, pop_en_o, ling_comp_en_o},
          {14'h0, miscs[m][6], miscs[m][7]});
    end
    wr(A_CMD, 8'h04);
    chk({15'h0, cmd_busy_o}, 16'h0000);
    wr(A_CMD, 8'h08);
    chk({15'h0, cmd_busy_o}, 16'h0001);
    // Deliberate write while busy: it must be refused
    frc_spi_host_i.xfer({1'b1, A_FRC, 8'h07}, rv);
    rd(A_FCNT);
    chk(rv, 16'h0001);
    rd(A_CMD);
    chk(rv, 16'h0000);
    rd(A_FRC);
    chk(rv, {5'h00, RNG_300, 8'h00});
    wr(A_CMD, 8'h02);
    chk({15'h0, cmd_busy_o}, 16'h0001);
    for (int i = 0; i < 6; i++)
    begin
      off[i] = 0;
      rd(A_OFF[i]);
      chk(rv, 16'h0000);
    end
    rd(A_FCNT);
    chk(rv, 16'h0002);
    // Tap 4 keeps the filter unchanged when auto-null drops the range
    wr(A_FRC, 8'h04);
    wsamp(40);
    wr(A_CMD, 8'h01);
    chk({15'h0, cmd_busy_o}, 16'h0001);
    rd(A_FRC);
    chk({13'h0, rv[10:8]}, {13'h0, RNG_75});
    for (int i = 0; i < 3; i++)
    begin
      rd(A_OFF[i]);
      chk(rv, 16'(-raw[i]) & 16'h1FFF);
    end
    wr(A_OFF[0], 8'h10);
    wr(A_CMD, 8'h80);
    chk({15'h0, cmd_busy_o}, 16'h0001);
    rd(A_OFF[0]);
    chk(rv, 16'(-raw[0]) & 16'h1FFF);
    stop_test();
  end
endmodule
